// *** dliu_pkg.sv ***
// Constants, types and helpers shared by the debug link instruction unit.
package dliu_pkg;

	// Instruction byte layout.
	localparam int OPC_MSB = 7;
	localparam int OPC_LSB = 5;
	localparam int PTR_MSB = 3;
	localparam int PTR_LSB = 2;
	localparam int SZ_MSB  = 1;
	localparam int SZ_LSB  = 0;
	localparam int CSA_MSB = 3;
	localparam int INFO_BIT = 2;

	localparam logic [2:0] OPC_READ_PTR  = 3'h1;
	localparam logic [2:0] OPC_WRITE_PTR = 3'h3;
	localparam logic [2:0] OPC_READ_CS   = 3'h4;
	localparam logic [2:0] OPC_REPEAT    = 3'h5;
	localparam logic [2:0] OPC_WRITE_CS  = 3'h6;
	localparam logic [2:0] OPC_KEY       = 3'h7;

	localparam logic [1:0] PTR_MODE_HOLD = 2'h0;
	localparam logic [1:0] PTR_MODE_INC  = 2'h1;
	localparam logic [1:0] PTR_MODE_REG  = 2'h2;
	localparam logic [1:0] SIZE_BYTE     = 2'h0;
	localparam logic [1:0] SIZE_WORD     = 2'h1;
	localparam logic [1:0] KEY_SIZE_64   = 2'h0;
	localparam logic [1:0] INFO_SIZE_128 = 2'h1;

	localparam logic [7:0] ACK_CHAR      = 8'h40;
	localparam logic [4:0] KEY_BYTES     = 5'h08;
	localparam logic [4:0] INFO_BYTES_S  = 5'h08;
	localparam logic [4:0] INFO_BYTES_L  = 5'h10;
	// Arbitrary identification content, not tied to any real part.
	localparam logic [127:0] INFO_BLOCK  = 128'h30303030_30303030_5858585858585858;

	// Control space and turnaround field.
	localparam int         CS_AW         = 4;
	localparam int         GT_W          = 3;
	localparam logic [3:0] CS_GUARD_ADDR = 4'h2;
	localparam logic [2:0] GT_RESET      = 3'h0;
	localparam logic [2:0] GT_NONE       = 3'h7;

	// Software register port.
	localparam logic [1:0] REG_GUARD   = 2'h0;
	localparam logic [1:0] REG_STATUS  = 2'h1;
	localparam logic [1:0] REG_POINTER = 2'h2;

	typedef enum logic [3:0] {
		S_WAIT_BAUD_TRAINING_CHAR = 4'h0,
		S_INSTR      = 4'h1,
		S_DEC        = 4'h2,
		S_OPND       = 4'h3,
		S_BUS        = 4'h4,
		S_CS_RD      = 4'h5,
		S_GUARD      = 4'h6,
		S_TX         = 4'h7
	} dliu_state_t;

	function automatic logic [4:0] size_bytes(input logic [1:0] s);
		return (s == SIZE_WORD) ? 5'h02 : 5'h01;
	endfunction : size_bytes

	function automatic logic size_ok(input logic [1:0] s);
		return (s == SIZE_BYTE) || (s == SIZE_WORD);
	endfunction : size_ok

	function automatic logic [7:0] guard_idle_bits(input logic [2:0] f);
		return (f == GT_NONE) ? 8'h00 : (8'h80 >> f);
	endfunction : guard_idle_bits

endpackage : dliu_pkg

// *** dliu_core_if.sv ***
// Internal carrier between the instruction core, guard timer and control space.
`timescale 1ns/100ps
interface dliu_core_if;
	import dliu_pkg::*;
	logic              gt_start;
	logic [7:0]        gt_bits;
	logic              gt_done;
	logic              cs_we;
	logic [CS_AW-1:0]  cs_addr;
	logic [7:0]        cs_wdata;
	logic [7:0]        cs_rdata;

	modport core  (output gt_start, gt_bits, cs_we, cs_addr, cs_wdata,
	               input  gt_done, cs_rdata);
	modport timer (input  gt_start, gt_bits, output gt_done);
	modport mem   (input  cs_we, cs_addr, cs_wdata, output cs_rdata);
endinterface : dliu_core_if

// *** dliu_cs_mem.sv ***
// Sixteen byte control and status space with registered read data.
`timescale 1ns/100ps
module dliu_cs_mem
	import dliu_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input  wire logic  i_clk,
	input  wire logic  i_resetn,
	dliu_core_if.mem   cif
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = mem[cif.cs_addr];
	end

	// The array itself has no reset; software must write before reading.
	always_ff @(posedge i_clk) begin
		if (cif.cs_we) begin
			mem[cif.cs_addr] <= cif.cs_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign cif.cs_rdata = rdata;
endmodule : dliu_cs_mem

// *** dliu_guard.sv ***
// Turnaround guard timer counting idle bits at the link baud rate.
`timescale 1ns/100ps
module dliu_guard
	import dliu_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_resetn,
	input  wire logic  i_baud_tick,
	dliu_core_if.timer cif
);
	logic [7:0] cnt;
	logic       run;
	logic       done;
	logic [7:0] next_cnt;
	logic       next_run;
	logic       next_done;

	always_comb begin
		next_cnt  = cnt;
		next_run  = run;
		next_done = 1'b0;
		if (cif.gt_start) begin
			next_cnt = cif.gt_bits;
			next_run = 1'b1;
		end else if (run) begin
			if (cnt == 8'h00) begin
				next_run  = 1'b0;
				next_done = 1'b1;
			end else if (i_baud_tick) begin
				next_cnt = cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt  <= 8'h00;
			run  <= 1'b0;
			done <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			run  <= next_run;
			done <= next_done;
		end
	end

	assign cif.gt_done = done;

	// Helper: idle bits seen since the last start.
	logic [7:0] want;
	logic [7:0] seen;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			want <= 8'h00;
			seen <= 8'h00;
		end else if (cif.gt_start) begin
			want <= cif.gt_bits;
			seen <= 8'h00;
		end else if (run && cnt != 8'h00 && i_baud_tick) begin
			seen <= seen + 8'h01;
		end
	end

	property p_gt_len;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(done) |-> seen == want;
	endproperty
	a_gt_len: assert property (p_gt_len)
		else $error("Guard ended with wrong idle bit count.");
endmodule : dliu_guard

// *** dliu_top.sv ***
// Instruction execution core of the single-wire debug link.
// Behaviour
// - Pointer read fetches bus data at the address pointer; operands up to 16 bits.
// - Size field 0 is one byte, 1 is a word; 2 and 3 are rejected.
// - Pointer read data and pointer readback leave only after the guard time.
// - Pointer write with mode 2 loads the pointer, then an acknowledge follows.
// - Mode 0 keeps the pointer; mode 1 advances it by data size after each read or write.
// - Each instruction follows a training character; pointer stores return an acknowledge.
// - Control read addresses the 16 byte space from the opcode, one byte only.
// - Control read byte is sent after the guard time.
// - Control write takes address from opcode, one byte, and gives no response.
// - Repeat loads an 8 bit count; next instruction runs count plus one times.
// - Repeated iterations take operands only; repeat itself is not repeated.
// - A repeat runs to its end unless a break character aborts it.
// - Without post-increment each repeated pointer access hits the same address.
// - Unlock code is exactly 64 bits in frames; no response is sent.
// - Info-block bit sends up to 128 bits after the guard time instead.
// - Each training character produces a capture event for the timer.
// - Idle bits at the current baud rate precede a turnaround transmission.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module dliu_top
	import dliu_pkg::*;
(
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_RX_VALID,
	input  wire logic [7:0]  I_RX_DATA,
	input  wire logic        I_RX_BAUD_TRAINING_CHAR,
	input  wire logic        I_RX_BREAK,
	input  wire logic        I_BAUD_TICK,
	output logic             O_TX_VALID,
	output logic [7:0]       O_TX_DATA,
	input  wire logic        I_TX_READY,
	output logic             O_BUS_REQ,
	output logic             O_BUS_WE,
	output logic [15:0]      O_BUS_ADDR,
	output logic [7:0]       O_BUS_WDATA,
	input  wire logic        I_BUS_ACK,
	input  wire logic [7:0]  I_BUS_RDATA,
	output logic             O_KEY_VALID,
	output logic [63:0]      O_KEY,
	output logic             O_CAPTURE_EVENT,
	input  wire logic [1:0]  I_REG_ADDR,
	input  wire logic [15:0] I_REG_WDATA,
	input  wire logic        I_REG_WR,
	input  wire logic        I_REG_RD,
	output logic [15:0]      O_REG_RDATA
);
	dliu_core_if u_if ();

	dliu_guard u_guard (
		.i_clk       (I_SYS_CLK),
		.i_resetn    (I_RESETN),
		.i_baud_tick (I_BAUD_TICK),
		.cif         (u_if.timer)
	);

	dliu_cs_mem #(.DEPTH(16)) u_mem (
		.i_clk    (I_SYS_CLK),
		.i_resetn (I_RESETN),
		.cif      (u_if.mem)
	);

	dliu_state_t     state, next_state;
	logic [7:0]      instr, next_instr;
	logic [127:0]    buffer, next_buffer;
	logic [4:0]      idx, next_idx;
	logic [4:0]      len, next_len;
	logic [15:0]     ptr, next_ptr;
	logic [7:0]      rpt, next_rpt;
	logic            need_gt, next_need_gt;
	logic [GT_W-1:0] guard, next_guard;
	logic            next_tx_valid, next_bus_req, next_bus_we;
	logic [7:0]      next_tx_data, next_bus_wdata;
	logic [15:0]     next_bus_addr, next_reg_rdata;
	logic            next_key_valid;
	logic [63:0]     next_key;
	logic            go_tx, finish;
	logic [2:0]      opc;
	logic [1:0]      pmode, sz;
	logic [4:0]      nb, nidx;

	assign opc   = instr[OPC_MSB:OPC_LSB];
	assign pmode = instr[PTR_MSB:PTR_LSB];
	assign sz    = instr[SZ_MSB:SZ_LSB];
	assign nb    = size_bytes(sz);
	assign nidx  = idx + 5'h01;

	always_comb begin
		next_state     = state;
		next_instr     = instr;
		next_buffer    = buffer;
		next_idx       = idx;
		next_len       = len;
		next_ptr       = ptr;
		next_rpt       = rpt;
		next_need_gt   = need_gt;
		next_guard     = guard;
		next_tx_valid  = O_TX_VALID;
		next_tx_data   = O_TX_DATA;
		next_bus_req   = O_BUS_REQ;
		next_bus_we    = O_BUS_WE;
		next_bus_addr  = O_BUS_ADDR;
		next_bus_wdata = O_BUS_WDATA;
		next_key_valid = 1'b0;
		next_key       = O_KEY;
		go_tx          = 1'b0;
		finish         = 1'b0;
		u_if.gt_start  = 1'b0;
		u_if.gt_bits   = 8'h00;
		u_if.cs_we     = 1'b0;
		u_if.cs_addr   = instr[CSA_MSB:0];
		u_if.cs_wdata  = I_RX_DATA;
		if (I_REG_WR && I_REG_ADDR == REG_GUARD) begin
			next_guard = I_REG_WDATA[GT_W-1:0];
		end
		next_reg_rdata = 16'h0000;
		if (I_REG_RD) begin
			unique case (I_REG_ADDR)
				REG_GUARD:   next_reg_rdata = {13'h0000, guard};
				REG_STATUS:  next_reg_rdata = {4'h0, state, rpt};
				REG_POINTER: next_reg_rdata = ptr;
				default:     next_reg_rdata = 16'h0000;
			endcase
		end
		unique case (state)
			S_WAIT_BAUD_TRAINING_CHAR: begin
				if (I_RX_BAUD_TRAINING_CHAR) next_state = S_INSTR;
			end
			S_INSTR: begin
				if (I_RX_VALID) begin
					next_instr   = I_RX_DATA;
					next_need_gt = 1'b1;
					next_state   = S_DEC;
				end
			end
			S_DEC: begin
				next_idx   = 5'h00;
				next_len   = nb;
				next_state = S_WAIT_BAUD_TRAINING_CHAR;
				unique case (opc)
					OPC_READ_PTR: begin
						if (size_ok(sz) && pmode == PTR_MODE_REG) begin
							next_buffer[15:0] = ptr;
							go_tx = 1'b1;
						end else if (size_ok(sz) && pmode != PTR_MODE_REG
						             && pmode[1] == 1'b0) begin
							next_bus_req  = 1'b1;
							next_bus_we   = 1'b0;
							next_bus_addr = ptr;
							next_state    = S_BUS;
						end
					end
					OPC_WRITE_PTR: begin
						if (size_ok(sz) && pmode != 2'h3) next_state = S_OPND;
					end
					OPC_READ_CS:  next_state = S_CS_RD;
					OPC_WRITE_CS: begin
						next_len   = 5'h01;
						next_state = S_OPND;
					end
					OPC_REPEAT: begin
						if (sz == SIZE_BYTE) next_state = S_OPND;
					end
					OPC_KEY: begin
						if (instr[INFO_BIT]) begin
							if (size_ok(sz)) begin
								next_buffer = INFO_BLOCK;
								next_len    = (sz == INFO_SIZE_128) ?
								              INFO_BYTES_L : INFO_BYTES_S;
								go_tx       = 1'b1;
							end
						end else if (sz == KEY_SIZE_64) begin
							next_len   = KEY_BYTES;
							next_state = S_OPND;
						end
					end
					default: next_state = S_WAIT_BAUD_TRAINING_CHAR;
				endcase
			end
			S_OPND: begin
				if (I_RX_VALID) begin
					next_buffer[idx*8 +: 8] = I_RX_DATA;
					next_idx     = nidx;
					next_need_gt = 1'b1;
					if (nidx == len) begin
						next_idx = 5'h00;
						unique case (opc)
							OPC_WRITE_PTR: begin
								if (pmode == PTR_MODE_REG) begin
									next_ptr = (len == 5'h01) ?
									  {8'h00, next_buffer[7:0]} :
									  next_buffer[15:0];
									next_buffer[7:0] = ACK_CHAR;
									next_len = 5'h01;
									go_tx    = 1'b1;
								end else begin
									next_bus_req   = 1'b1;
									next_bus_we    = 1'b1;
									next_bus_addr  = ptr;
									next_bus_wdata = next_buffer[7:0];
									next_state     = S_BUS;
								end
							end
							OPC_WRITE_CS: begin
								u_if.cs_we = 1'b1;
								if (instr[CSA_MSB:0] == CS_GUARD_ADDR) begin
									next_guard = I_RX_DATA[GT_W-1:0];
								end
								finish = 1'b1;
							end
							OPC_REPEAT: begin
								next_rpt   = I_RX_DATA;
								next_state = S_WAIT_BAUD_TRAINING_CHAR;
							end
							default: begin
								next_key_valid = 1'b1;
								next_key       = next_buffer[63:0];
								finish         = 1'b1;
							end
						endcase
					end
				end
			end
			S_BUS: begin
				if (I_BUS_ACK) begin
					next_bus_req = 1'b0;
					if (!O_BUS_WE) next_buffer[idx*8 +: 8] = I_BUS_RDATA;
					next_idx = nidx;
					if (nidx != len) begin
						next_bus_req   = 1'b1;
						next_bus_addr  = ptr + {11'h000, nidx};
						next_bus_wdata = buffer[nidx*8 +: 8];
					end else begin
						if (pmode == PTR_MODE_INC) begin
							next_ptr = ptr + {11'h000, len};
						end
						if (O_BUS_WE) begin
							next_buffer[7:0] = ACK_CHAR;
							next_len = 5'h01;
						end
						go_tx = 1'b1;
					end
				end
			end
			S_CS_RD: begin
				// The guard field lives in a register that software can also write,
				// so its readback must come from there, not from the stale array.
				if (instr[CSA_MSB:0] == CS_GUARD_ADDR) begin
					next_buffer[7:0] = {{(8-GT_W){1'b0}}, guard};
				end else begin
					next_buffer[7:0] = u_if.cs_rdata;
				end
				next_len = 5'h01;
				go_tx    = 1'b1;
			end
			S_GUARD: begin
				if (u_if.gt_done) begin
					next_tx_valid = 1'b1;
					next_tx_data  = buffer[7:0];
					next_state    = S_TX;
				end
			end
			S_TX: begin
				if (O_TX_VALID && I_TX_READY) begin
					next_idx     = nidx;
					next_tx_data = buffer[nidx*8 +: 8];
					if (nidx == len) begin
						next_tx_valid = 1'b0;
						finish        = 1'b1;
					end
				end
			end
			default: next_state = S_WAIT_BAUD_TRAINING_CHAR;
		endcase
		// A repeat re-runs the held instruction without a new frame.
		if (finish) begin
			if (rpt != 8'h00) begin
				next_rpt   = rpt - 8'h01;
				next_state = S_DEC;
			end else begin
				next_state = S_WAIT_BAUD_TRAINING_CHAR;
			end
		end
		if (go_tx) begin
			u_if.gt_start = 1'b1;
			u_if.gt_bits  = next_need_gt ? guard_idle_bits(guard) : 8'h00;
			next_need_gt  = 1'b0;
			next_idx      = 5'h00;
			next_state    = S_GUARD;
		end
		// Break wins over state, repeat count, transmit and bus request, including a bus cycle in flight.
		if (I_RX_BREAK) begin
			next_state    = S_WAIT_BAUD_TRAINING_CHAR;
			next_rpt      = 8'h00;
			next_tx_valid = 1'b0;
			next_bus_req  = 1'b0;
			u_if.gt_start = 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state           <= S_WAIT_BAUD_TRAINING_CHAR;
			instr           <= 8'h00;
			buffer          <= '0;
			idx             <= 5'h00;
			len             <= 5'h00;
			ptr             <= 16'h0000;
			rpt             <= 8'h00;
			need_gt         <= 1'b0;
			guard           <= GT_RESET;
			O_TX_VALID      <= 1'b0;
			O_TX_DATA       <= 8'h00;
			O_BUS_REQ       <= 1'b0;
			O_BUS_WE        <= 1'b0;
			O_BUS_ADDR      <= 16'h0000;
			O_BUS_WDATA     <= 8'h00;
			O_KEY_VALID     <= 1'b0;
			O_KEY           <= 64'h0000_0000_0000_0000;
			O_CAPTURE_EVENT <= 1'b0;
			O_REG_RDATA     <= 16'h0000;
		end else begin
			state           <= next_state;
			instr           <= next_instr;
			buffer          <= next_buffer;
			idx             <= next_idx;
			len             <= next_len;
			ptr             <= next_ptr;
			rpt             <= next_rpt;
			need_gt         <= next_need_gt;
			guard           <= next_guard;
			O_TX_VALID      <= next_tx_valid;
			O_TX_DATA       <= next_tx_data;
			O_BUS_REQ       <= next_bus_req;
			O_BUS_WE        <= next_bus_we;
			O_BUS_ADDR      <= next_bus_addr;
			O_BUS_WDATA     <= next_bus_wdata;
			O_KEY_VALID     <= next_key_valid;
			O_KEY           <= next_key;
			O_CAPTURE_EVENT <= I_RX_BAUD_TRAINING_CHAR;
			O_REG_RDATA     <= next_reg_rdata;
		end
	end

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);

	sequence s_last_ack;
		state == S_BUS && I_BUS_ACK && nidx == len && !I_RX_BREAK;
	endsequence

	property p_sync_event;
		I_RX_BAUD_TRAINING_CHAR |=> O_CAPTURE_EVENT;
	endproperty
	a_sync_event: assert property (p_sync_event)
		else $error("Training character gave no capture event.");

	property p_break;
		I_RX_BREAK |=> state == S_WAIT_BAUD_TRAINING_CHAR && rpt == 8'h00 && !O_TX_VALID;
	endproperty
	a_break: assert property (p_break)
		else $error("Break did not abort the sequence.");

	property p_ptr_inc;
		s_last_ack ##0 pmode == PTR_MODE_INC |=>
			ptr == $past(ptr) + {11'h000, $past(len)};
	endproperty
	a_ptr_inc: assert property (p_ptr_inc)
		else $error("Pointer not advanced by data size.");

	property p_ptr_hold;
		state == S_BUS && pmode == PTR_MODE_HOLD |=> ptr == $past(ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("Pointer moved in hold mode.");

	property p_bus_addr;
		O_BUS_REQ |-> O_BUS_ADDR == ptr + {11'h000, idx};
	endproperty
	a_bus_addr: assert property (p_bus_addr)
		else $error("Bus address differs from pointer plus offset.");

	property p_guard_first;
		state == S_GUARD && !u_if.gt_done |=> !O_TX_VALID;
	endproperty
	a_guard_first: assert property (p_guard_first)
		else $error("Transmit started before the guard time ended.");

	property p_cs_silent;
		u_if.cs_we && !I_RX_BREAK |=> state != S_GUARD ##1 !O_TX_VALID;
	endproperty
	a_cs_silent: assert property (p_cs_silent)
		else $error("Control write produced a response.");

	property p_repeat_step;
		finish && rpt != 8'h00 && !go_tx && !I_RX_BREAK |=>
			rpt == $past(rpt) - 8'h01 && state == S_DEC;
	endproperty
	a_repeat_step: assert property (p_repeat_step)
		else $error("Repeat count did not step.");

	property p_key_silent;
		O_KEY_VALID |-> !O_TX_VALID && state != S_GUARD;
	endproperty
	a_key_silent: assert property (p_key_silent)
		else $error("Unlock code answered.");

	property p_ack_after_store;
		s_last_ack ##0 O_BUS_WE |=> state == S_GUARD && buffer[7:0] == ACK_CHAR;
	endproperty
	a_ack_after_store: assert property (p_ack_after_store)
		else $error("Store not followed by an acknowledge.");
endmodule : dliu_top

// *** dliu_far_model.sv ***
// Far side model: link PHY with baud ticks, byte sink and system bus memory.
`timescale 1ns/100ps
module dliu_far_model (
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	input  wire logic        i_rx_valid,
	input  wire logic        i_tx_valid,
	input  wire logic [7:0]  i_tx_data,
	output logic             o_tx_ready,
	output logic             o_baud_tick,
	input  wire logic        i_bus_req,
	input  wire logic        i_bus_we,
	input  wire logic [15:0] i_bus_addr,
	input  wire logic [7:0]  i_bus_wdata,
	output logic             o_bus_ack,
	output logic [7:0]       o_bus_rdata
);
	logic [7:0] mem [int];
	logic [7:0] tx_q [$];
	int         tick_q [$];
	int         ticks = 0;
	int         cyc = 0;
	int         wait_n = 0;

	initial begin
		o_tx_ready  = 1'b0;
		o_baud_tick = 1'b0;
		o_bus_ack   = 1'b0;
		o_bus_rdata = 8'hA5;
	end

	always @(posedge i_clk) begin
		cyc++;
		o_baud_tick <= (cyc % 4 == 0);
		o_tx_ready  <= !i_slow || (cyc % 3 == 0);
		// Ticks since the last received byte bound the idle time seen.
		if (o_baud_tick)
			ticks++;
		if (i_rx_valid)
			ticks = 0;
		if (i_tx_valid && o_tx_ready) begin
			tx_q.push_back(i_tx_data);
			tick_q.push_back(ticks);
		end
		o_bus_ack <= 1'b0;
		// A released bus shows a changing pattern, never the last value.
		o_bus_rdata <= ~o_bus_rdata;
		if (i_bus_req && !o_bus_ack) begin
			if (wait_n < (i_slow ? 3 : 0)) begin
				wait_n++;
			end else begin
				wait_n = 0;
				o_bus_ack <= 1'b1;
				if (i_bus_we)
					mem[i_bus_addr] = i_bus_wdata;
				else if (mem.exists(i_bus_addr))
					o_bus_rdata <= mem[i_bus_addr];
				else
					o_bus_rdata <= i_bus_addr[7:0] ^ 8'h5A;
			end
		end
	end
endmodule : dliu_far_model

// *** dliu_top_tb.sv ***
// Self-checking bench for the debug link instruction unit.
`timescale 1ns/100ps
module dliu_top_tb;
	import dliu_pkg::*;
	typedef struct {
		logic [7:0]  instr;
		int          nop;
		logic [15:0] op;
		int          nrsp;
		logic [15:0] rsp;
	} dliu_row_t;

	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        rx_valid = 1'b0;
	logic [7:0]  rx_data = 8'h00;
	logic        rx_baud_training_char = 1'b0;
	logic        rx_break = 1'b0;
	logic        slow = 1'b0;
	logic [1:0]  reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        tx_valid, tx_ready, baud_tick, bus_req, bus_we, bus_ack;
	logic        key_valid, capture;
	logic [7:0]  tx_data, bus_wdata, bus_rdata;
	logic [15:0] bus_addr, reg_rdata;
	logic [63:0] key;
	int          fail_count = 0;
	int          check_count = 0;
	int          gbits = 128;
	int          key_hits = 0;
	int          cap_hits = 0;
	int          baud_training_char_n = 0;
	dliu_row_t   rows [21] = '{
		'{8'h82, 0, 16'h0000, 1, 16'h0000},
		'{8'h69, 2, 16'h1234, 1, 16'h0040}, '{8'h64, 1, 16'h005A, 1, 16'h0040},
		'{8'h61, 2, 16'h2211, 1, 16'h0040}, '{8'h29, 0, 16'h0000, 2, 16'h1235},
		'{8'h21, 0, 16'h0000, 2, 16'h2211}, '{8'hC2, 1, 16'h0005, 0, 16'h0000},
		'{8'h82, 0, 16'h0000, 1, 16'h0005}, '{8'h62, 0, 16'h0000, 0, 16'h0000},
		'{8'h23, 0, 16'h0000, 0, 16'h0000}, '{8'h00, 0, 16'h0000, 0, 16'h0000},
		'{8'h40, 0, 16'h0000, 0, 16'h0000}, '{8'h2D, 0, 16'h0000, 0, 16'h0000},
		'{8'h6D, 0, 16'h0000, 0, 16'h0000}, '{8'hE1, 0, 16'h0000, 0, 16'h0000},
		'{8'hA1, 0, 16'h0000, 0, 16'h0000}, '{8'hC5, 1, 16'h00A7, 0, 16'h0000},
		'{8'h85, 0, 16'h0000, 1, 16'h00A7},
		'{8'h24, 0, 16'h0000, 1, 16'h0011}, '{8'h20, 0, 16'h0000, 1, 16'h0022},
		'{8'h28, 0, 16'h0000, 1, 16'h0036}};

	dliu_top DUT (.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .I_RX_VALID(rx_valid),
		.I_RX_DATA(rx_data), .I_RX_BAUD_TRAINING_CHAR(rx_baud_training_char), .I_RX_BREAK(rx_break),
		.I_BAUD_TICK(baud_tick), .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data),
		.I_TX_READY(tx_ready), .O_BUS_REQ(bus_req), .O_BUS_WE(bus_we),
		.O_BUS_ADDR(bus_addr), .O_BUS_WDATA(bus_wdata), .I_BUS_ACK(bus_ack),
		.I_BUS_RDATA(bus_rdata), .O_KEY_VALID(key_valid), .O_KEY(key),
		.O_CAPTURE_EVENT(capture), .I_REG_ADDR(reg_addr),
		.I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
		.O_REG_RDATA(reg_rdata));

	dliu_far_model far (.i_clk(sys_clk), .i_slow(slow), .i_rx_valid(rx_valid),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
		.o_baud_tick(baud_tick), .i_bus_req(bus_req), .i_bus_we(bus_we),
		.i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata), .o_bus_ack(bus_ack),
		.o_bus_rdata(bus_rdata));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (key_valid === 1'b1)
			key_hits++;
		if (capture === 1'b1)
			cap_hits++;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic send(input logic [7:0] b);
		@(posedge sys_clk);
		rx_valid <= 1'b1;
		rx_data  <= b;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : send

	task automatic baud_training_char();
		baud_training_char_n++;
		@(posedge sys_clk);
		rx_baud_training_char <= 1'b1;
		@(posedge sys_clk);
		rx_baud_training_char <= 1'b0;
		#1 chk("capture", capture, 1'b1);
		repeat (3) @(posedge sys_clk);
	endtask : baud_training_char

	task automatic get(input logic [7:0] exp);
		int n;
		int t;
		n = 0;
		while (far.tx_q.size() == 0 && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		if (far.tx_q.size() == 0) begin
			chk("tx present", 1'b0, 1'b1);
		end else begin
			t = far.tick_q.pop_front();
			chk("tx byte", far.tx_q.pop_front(), exp);
			chk("guard", t >= gbits, 1'b1);
		end
	endtask : get

	task automatic quiet();
		repeat (600) @(posedge sys_clk);
		chk("extra tx", far.tx_q.size(), 0);
	endtask : quiet

	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("reg read", reg_rdata, exp);
	endtask : rd

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic ptr_load(input logic [15:0] a);
		baud_training_char();
		send(8'h69);
		send(a[7:0]);
		send(a[15:8]);
		get(ACK_CHAR);
	endtask : ptr_load

	task automatic rpt(input logic [7:0] n);
		baud_training_char();
		send(8'hA0);
		send(n);
	endtask : rpt

	initial begin
		#800000;
		fail_count++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		chk("reset out", {tx_valid, bus_req, key_valid, capture,
		    reg_rdata}, 0);
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(REG_GUARD, 16'h0000);
		rd(REG_STATUS, 16'h0000);
		rd(REG_POINTER, 16'h0000);
		for (int i = 0; i < 21; i++) begin
			baud_training_char();
			send(rows[i].instr);
			for (int j = 0; j < rows[i].nop; j++)
				send(rows[i].op[8*j +: 8]);
			if (rows[i].instr == 8'hC2)
				gbits = 128 >> rows[i].op[2:0];
			for (int j = 0; j < rows[i].nrsp; j++)
				get(rows[i].rsp[8*j +: 8]);
			quiet();
		end
		rd(REG_POINTER, 16'h1236);
		wr(2'h3, 16'hFFFF);
		rd(2'h3, 16'h0000);
		wr(REG_GUARD, 16'h0006);
		rd(REG_GUARD, 16'h0006);
		gbits = 2;
		baud_training_char();
		send(8'h82);
		get(8'h06);
		baud_training_char();
		send(8'hE0);
		for (int k = 0; k < 8; k++)
			send(8'(16 + k));
		quiet();
		chk("key pulses", key_hits, 1);
		chk("key", key, 64'h1716151413121110);
		for (int k = 0; k < 2; k++) begin
			baud_training_char();
			send(8'hE4 | 8'(k));
			repeat (600) @(posedge sys_clk);
			chk("info bytes", far.tx_q.size(), 8 << k);
			chk("info last", far.tx_q[(8 << k) - 1],
			    INFO_BLOCK[(64 << k) - 8 +: 8]);
			far.tx_q.delete();
			far.tick_q.delete();
		end
		// Slow bus and link from here on; each repeated store frame waits for its ack.
		slow <= 1'b1;
		ptr_load(16'h2000);
		rpt(8'h02);
		baud_training_char();
		send(8'h64);
		for (int k = 0; k < 3; k++) begin
			send(8'(192 + k));
			get(ACK_CHAR);
		end
		quiet();
		rd(REG_POINTER, 16'h2003);
		ptr_load(16'h2000);
		rpt(8'h02);
		baud_training_char();
		send(8'h24);
		for (int k = 0; k < 3; k++)
			get(8'(192 + k));
		quiet();
		ptr_load(16'h2000);
		rpt(8'h05);
		baud_training_char();
		send(8'h64);
		send(8'hD0);
		get(ACK_CHAR);
		@(posedge sys_clk);
		rx_break <= 1'b1;
		@(posedge sys_clk);
		rx_break <= 1'b0;
		send(8'hD1);
		quiet();
		rd(REG_POINTER, 16'h2001);
		ptr_load(16'h2000);
		baud_training_char();
		send(8'h20);
		get(8'hD0);
		chk("captures", cap_hits, baud_training_char_n);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("reset out", {tx_valid, bus_req, key_valid, capture,
		    reg_rdata}, 0);
		resetn <= 1'b1;
		rd(REG_POINTER, 16'h0000);
		rd(REG_GUARD, 16'h0000);
		close_out();
	end
endmodule : dliu_top_tb
